// *** pkg/rpe_consts.svh ***
// Constants of the relay parameter and event interface: addresses, ranges, codes.
// Assumes a 16-bit data register port and a 50 MHz clock.
`ifndef RPE_CONSTS_SVH
`define RPE_CONSTS_SVH
// ===========================================================================
// Register indices on the parameter port.
`define RPE_A_IND_RESET 8'h00
`define RPE_A_FULL_RESET 8'h01
`define RPE_A_BANK 8'h02
`define RPE_A_OC_MASK 8'h03
`define RPE_A_RES_MASK 8'h04
`define RPE_A_OUTA_MASK 8'h05
`define RPE_A_OUTB_MASK 8'h06
`define RPE_A_PW_OPEN 8'h07
`define RPE_A_PW_CHANGE 8'h08
`define RPE_A_SUP_ACT 8'h09
`define RPE_A_FORMAT 8'h0A
`define RPE_A_FAULT 8'h0B
`define RPE_A_STATION 8'h0C
`define RPE_A_EVT_CMD 8'h0D
`define RPE_A_EVT_COUNT 8'h0E
`define RPE_A_MOD_STATE 8'h0F
`define RPE_A_TIME 8'h10
`define RPE_A_REMOTE 8'h11
`define RPE_A_BUF_BASE 8'h20
`define RPE_A_BUF_LAST 8'h29
// ===========================================================================
// Command values and accepted ranges.
`define RPE_V_ONE 16'h0001
`define RPE_V_ZERO 16'h0000
`define RPE_V_FORMAT 16'h0002
`define RPE_V_EVT_READ 16'h0001
`define RPE_V_EVT_REREAD 16'h0002
`define RPE_MAX_MASK_WIDE 16'h1000
`define RPE_MAX_MASK_A 16'h00FF
`define RPE_MAX_MASK_B 16'h03FF
`define RPE_MAX_PW 16'h03E7
`define RPE_MAX_STATION 16'h00FE
`define RPE_MAX_TIME_MS 16'hEA5F
`define RPE_PW_DEFAULT 10'h001
`define RPE_STATION_DEFAULT 8'h01
// ===========================================================================
// Event register geometry.
`define RPE_EVT_DEPTH 7'h41
`define RPE_EVT_BATCH 3'h5
`define RPE_EVT_LAST_PTR 7'h40
// ===========================================================================
// Fault flag bit positions and fault codes.
`define RPE_F_CTRL 0
`define RPE_F_ROM 1
`define RPE_F_RAM 2
`define RPE_F_EE1 3
`define RPE_F_EE2 4
`define RPE_F_CKSUM 5
`define RPE_F_KEY 6
`define RPE_F_REF_LOW 7
`define RPE_F_REF_HIGH 8
`define RPE_F_FILTER 9
`define RPE_F_ADC 10
`define RPE_C_CTRL 8'h04
`define RPE_C_ROM 8'h1E
`define RPE_C_RAM 8'h32
`define RPE_C_EE1 8'h33
`define RPE_C_EE2 8'h34
`define RPE_C_EE12 8'h35
`define RPE_C_CKSUM 8'h36
`define RPE_C_KEY 8'h38
`define RPE_C_LOW_G1 8'hC3
`define RPE_C_LOW_G5 8'h83
`define RPE_C_LOW_G25 8'h43
`define RPE_C_HIGH_G1 8'hCB
`define RPE_C_HIGH_G5 8'h8B
`define RPE_C_HIGH_G25 8'h4B
`define RPE_C_FILTER 8'hFC
`define RPE_C_ADC 8'hFD
`define RPE_GAIN_5 2'h1
`define RPE_GAIN_25 2'h2
// ===========================================================================
// Timing: one millisecond tick.
`define RPE_TICK_NS 1000000
`define RPE_CLK_NS 20
`endif

// *** pkg/rpe_pkg.sv ***
// Types of the relay parameter and event interface.
// Assumes the constants header is on the include path.
`include "rpe_consts.svh"
package rpe_pkg;
   // ========================================================================
   // The whole state of the block as one packed record.
   typedef struct packed {
      logic [64:0][31:0] mem;   // Event ring: time, channel, code.
      logic [6:0] rd_ptr;       // Oldest undelivered event.
      logic [6:0] wr_ptr;       // Next free slot.
      logic [6:0] count;        // Undelivered events held.
      logic [4:0][31:0] buf_evt; // Events of the last read, kept for re-reading.
      logic [2:0] buf_count;    // Valid entries in the re-read buffer.
      logic [12:0] oc_mask;
      logic [12:0] res_mask;
      logic [7:0] outa_mask;
      logic [9:0] outb_mask;
      logic bank_select;
      logic [9:0] password;
      logic remote_open;
      logic [7:0] station;
      logic [1:0] mod_state;    // Bit 0 automatic reset, bit 1 overflow.
      logic [15:0] time_ms;
      logic [31:0] prescale;
      logic sup_active;
      logic [7:0] fault_code;
      logic fault_lit;          // Internal fault indicator lit.
      logic alarm_energized;
      logic ind_clear;
      logic relay_release;
      logic records_clear;
      logic format_start;
      logic [15:0] rdata;
   } rpe_state_t;
endpackage

// *** hdl/rpe_top.sv ***
// Parameter, command and event register logic of a protection relay module.
// Assumes a same-clock bus front end drives the port, and that fault flags,
// events and the automatic-reset pulse come from logic on the same clock.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`include "rpe_consts.svh"

module rpe_top #(
   parameter int CYC_PER_MS = (`RPE_TICK_NS + `RPE_CLK_NS - 1) / `RPE_CLK_NS
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic resetn,
   // Register port.
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   // Event source.
   input wire logic evt_valid,
   input wire logic [7:0] evt_channel,
   input wire logic [7:0] evt_code,
   // Supervision inputs.
   input wire logic [10:0] fault_flags,
   input wire logic [1:0] ref_gain,
   input wire logic auto_reset_event,
   // Relay side outputs.
   output logic indicators_clear,
   output logic latch_release,
   output logic records_clear,
   output logic bank_select,
   output logic format_start,
   output logic internal_fault_indicator,
   output logic alarm_relay_energized,
   output logic remote_open
);
   // ========================================================================
   // State register and its next value.
   rpe_pkg::rpe_state_t s;
   rpe_pkg::rpe_state_t next_s;
   localparam logic [31:0] TICK_LAST = 32'(CYC_PER_MS - 1);

   // Ring pointer advance; the ring is not a power of two, so wrap by hand.
   function automatic logic [6:0] rpe_wrap(input logic [6:0] p, input logic [2:0] k);
      logic [7:0] t;
      t = {1'b0, p} + {5'b0_0000, k};
      if (t >= {1'b0, `RPE_EVT_DEPTH}) begin
         t = t - {1'b0, `RPE_EVT_DEPTH};
      end
      return t[6:0];
   endfunction

   // Mask gate: channels 0 to 3 are masked by code bit, others pass.
   function automatic logic rpe_pass(input rpe_pkg::rpe_state_t st,
                                     input logic [7:0] ch, input logic [7:0] code);
      logic p;
      p = 1'b1;
      case (ch)
         8'h00: p = (code < 8'h0D) && st.oc_mask[code[3:0]];
         8'h01: p = (code < 8'h0D) && st.res_mask[code[3:0]];
         8'h02: p = (code < 8'h08) && st.outa_mask[code[2:0]];
         8'h03: p = (code < 8'h0A) && st.outb_mask[code[3:0]];
         default: p = 1'b1;
      endcase
      return p;
   endfunction

   // Fault encoder: the earliest listed fault wins when several are present; EE1 with EE2 gives the combined code.
   function automatic logic [7:0] rpe_fault(input logic [10:0] f, input logic [1:0] g);
      logic [7:0] c;
      c = 8'h00;
      if (f[`RPE_F_CTRL]) begin
         c = `RPE_C_CTRL;
      end else if (f[`RPE_F_ROM]) begin
         c = `RPE_C_ROM;
      end else if (f[`RPE_F_RAM]) begin
         c = `RPE_C_RAM;
      end else if (f[`RPE_F_EE1] && f[`RPE_F_EE2]) begin
         c = `RPE_C_EE12;
      end else if (f[`RPE_F_EE1]) begin
         c = `RPE_C_EE1;
      end else if (f[`RPE_F_EE2]) begin
         c = `RPE_C_EE2;
      end else if (f[`RPE_F_CKSUM]) begin
         c = `RPE_C_CKSUM;
      end else if (f[`RPE_F_KEY]) begin
         c = `RPE_C_KEY;
      end else if (f[`RPE_F_REF_LOW]) begin
         c = (g == `RPE_GAIN_25) ? `RPE_C_LOW_G25 :
             (g == `RPE_GAIN_5) ? `RPE_C_LOW_G5 : `RPE_C_LOW_G1;
      end else if (f[`RPE_F_REF_HIGH]) begin
         c = (g == `RPE_GAIN_25) ? `RPE_C_HIGH_G25 :
             (g == `RPE_GAIN_5) ? `RPE_C_HIGH_G5 : `RPE_C_HIGH_G1;
      end else if (f[`RPE_F_FILTER]) begin
         c = `RPE_C_FILTER;
      end else if (f[`RPE_F_ADC]) begin
         c = `RPE_C_ADC;
      end
      return c;
   endfunction

   // ========================================================================
   // Next-state logic: commands, event ring, time base and supervision.
   always_comb begin
      logic [2:0] take;
      logic [7:0] bi;
      logic [6:0] cnt;
      take = 3'h0;
      bi = 8'h00;
      cnt = s.count;
      next_s = s;
      // Command pulses last one cycle.
      next_s.ind_clear = 1'b0;
      next_s.relay_release = 1'b0;
      next_s.records_clear = 1'b0;
      next_s.format_start = 1'b0;
      next_s.rdata = 16'h0000;
      // Time base: one millisecond per tick, wrapping after 59.999 s.
      // millisecond time count
      if (s.prescale >= TICK_LAST) begin
         next_s.prescale = 32'h0000_0000;
         next_s.time_ms = (s.time_ms >= `RPE_MAX_TIME_MS) ? 16'h0000 : s.time_ms + 16'h0001;
      end else begin
         next_s.prescale = s.prescale + 32'h0000_0001;
      end
      // Writes; every out-of-range value is dropped without effect.
      if (wr) begin
         case (addr)
            `RPE_A_IND_RESET: if (wdata == `RPE_V_ONE) begin
               next_s.ind_clear = 1'b1;
               next_s.relay_release = 1'b1;
               next_s.sup_active = 1'b0;
            end
            `RPE_A_FULL_RESET: if (wdata == `RPE_V_ONE) begin
               next_s.ind_clear = 1'b1;
               next_s.relay_release = 1'b1;
               next_s.records_clear = 1'b1;
               next_s.sup_active = 1'b0;
            end
            `RPE_A_BANK: if (wdata <= `RPE_V_ONE) begin
               next_s.bank_select = wdata[0];
            end
            `RPE_A_OC_MASK: if (wdata <= `RPE_MAX_MASK_WIDE) begin
               next_s.oc_mask = wdata[12:0];
            end
            `RPE_A_RES_MASK: if (wdata <= `RPE_MAX_MASK_WIDE) begin
               next_s.res_mask = wdata[12:0];
            end
            `RPE_A_OUTA_MASK: if (wdata <= `RPE_MAX_MASK_A) begin
               next_s.outa_mask = wdata[7:0];
            end
            `RPE_A_OUTB_MASK: if (wdata <= `RPE_MAX_MASK_B) begin
               next_s.outb_mask = wdata[9:0];
            end
            `RPE_A_PW_OPEN: if (wdata != `RPE_V_ZERO && wdata <= `RPE_MAX_PW &&
                                wdata[9:0] == s.password) begin
               next_s.remote_open = 1'b1;
            end
            `RPE_A_PW_CHANGE: if (s.remote_open && wdata <= `RPE_MAX_PW) begin
               next_s.password = wdata[9:0];
               next_s.remote_open = 1'b0;
            end
            `RPE_A_SUP_ACT: if (wdata == `RPE_V_ONE) begin
               next_s.sup_active = 1'b1;
            end
            `RPE_A_FORMAT: if (s.remote_open && wdata == `RPE_V_FORMAT) begin
               next_s.format_start = 1'b1;
            end
            `RPE_A_STATION: if (wdata != `RPE_V_ZERO && wdata <= `RPE_MAX_STATION) begin
               next_s.station = wdata[7:0];
            end
            `RPE_A_EVT_CMD: if (wdata == `RPE_V_EVT_READ) begin
               take = (s.count > {4'h0, `RPE_EVT_BATCH}) ? `RPE_EVT_BATCH : s.count[2:0];
               for (int k = 0; k < 5; k++) begin
                  next_s.buf_evt[k] = (3'(k) < take) ? s.mem[rpe_wrap(s.rd_ptr, 3'(k))]
                                                     : 32'h0000_0000;
               end
               next_s.buf_count = take;
               next_s.rd_ptr = rpe_wrap(s.rd_ptr, take);
            end
            `RPE_A_MOD_STATE: if (wdata == `RPE_V_ZERO) begin
               next_s.mod_state = 2'b00;
            end
            `RPE_A_TIME: if (wdata <= `RPE_MAX_TIME_MS) begin
               next_s.time_ms = wdata;
               next_s.prescale = 32'h0000_0000;
            end
            default: begin
            end
         endcase
      end
      // Incoming event: a full ring drops it and flags overflow.
      // bounded event ring
      cnt = s.count - {4'h0, take};
      if (evt_valid && rpe_pass(s, evt_channel, evt_code)) begin
         if (s.count < `RPE_EVT_DEPTH) begin
            next_s.mem[s.wr_ptr] = {s.time_ms, evt_channel, evt_code};
            next_s.wr_ptr = (s.wr_ptr == `RPE_EVT_LAST_PTR) ? 7'h00 : s.wr_ptr + 7'h01;
            cnt = cnt + 7'h01;
         end else begin
            next_s.mod_state[1] = 1'b1;
         end
      end
      next_s.count = cnt;
      // Hardware events win over a clear in the same cycle.
      // state bits set
      if (auto_reset_event) begin
         next_s.mod_state[0] = 1'b1;
      end
      // Reads: data stand in the following cycle only.
      if (rd) begin
         case (addr)
            `RPE_A_BANK: next_s.rdata = {15'h0000, s.bank_select};
            `RPE_A_OC_MASK: next_s.rdata = {3'h0, s.oc_mask};
            `RPE_A_RES_MASK: next_s.rdata = {3'h0, s.res_mask};
            `RPE_A_OUTA_MASK: next_s.rdata = {8'h00, s.outa_mask};
            `RPE_A_OUTB_MASK: next_s.rdata = {6'h00, s.outb_mask};
            `RPE_A_FAULT: next_s.rdata = {8'h00, s.fault_code};
            `RPE_A_STATION: next_s.rdata = {8'h00, s.station};
            `RPE_A_EVT_COUNT: next_s.rdata = {9'h000, s.count};
            `RPE_A_EVT_CMD: next_s.rdata = {13'h0000, s.buf_count};
            `RPE_A_MOD_STATE: next_s.rdata = {14'h0000, s.mod_state};
            `RPE_A_TIME: next_s.rdata = s.time_ms;
            `RPE_A_REMOTE: next_s.rdata = {15'h0000, s.remote_open};
            default: begin
               if (addr >= `RPE_A_BUF_BASE && addr <= `RPE_A_BUF_LAST) begin
                  bi = addr - `RPE_A_BUF_BASE;
                  next_s.rdata = bi[0] ? s.buf_evt[bi[3:1]][15:0] : s.buf_evt[bi[3:1]][31:16];
               end
            end
         endcase
      end
      // Supervision: indicator and alarm relay always change together.
      // fault code encoding
      next_s.fault_code = rpe_fault(fault_flags, ref_gain);
      next_s.fault_lit = (fault_flags != 11'h000) || next_s.sup_active;
      next_s.alarm_energized = !next_s.fault_lit;
   end

   // ========================================================================
   // State flip-flops; reset loads constants only.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         s.password <= `RPE_PW_DEFAULT;
         s.station <= `RPE_STATION_DEFAULT;
         s.alarm_energized <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // Outputs come straight from the state record.
   // Taking every pin from a flip-flop keeps the relay side free of decode glitches.
   assign rdata = s.rdata;
   assign indicators_clear = s.ind_clear;
   assign latch_release = s.relay_release;
   assign records_clear = s.records_clear;
   assign bank_select = s.bank_select;
   assign format_start = s.format_start;
   assign internal_fault_indicator = s.fault_lit;
   assign alarm_relay_energized = s.alarm_energized;
   assign remote_open = s.remote_open;

   // ========================================================================
   // Assertions and covers.
   // Covers mark the main scenarios: overflow, batch read, opening, format and wrap.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   a_ind_reset_pulse: assert property (
      wr && addr == `RPE_A_IND_RESET && wdata == `RPE_V_ONE |=>
         indicators_clear && latch_release && !records_clear ##1 !indicators_clear)
      else $error("indicator reset pulse wrong");
   a_full_reset_pulse: assert property (
      wr && addr == `RPE_A_FULL_RESET && wdata == `RPE_V_ONE |=>
         indicators_clear && latch_release && records_clear)
      else $error("full reset pulse missing");
   a_bank_follows_write: assert property (
      wr && addr == `RPE_A_BANK && wdata <= `RPE_V_ONE |=> bank_select == $past(wdata[0]))
      else $error("bank select did not follow write");
   a_mask_range_reject: assert property (
      wr && addr == `RPE_A_OC_MASK && wdata > `RPE_MAX_MASK_WIDE |=> $stable(s.oc_mask))
      else $error("out of range mask stored");
   a_outb_mask_store: assert property (
      wr && addr == `RPE_A_OUTB_MASK && wdata <= `RPE_MAX_MASK_B |=>
         s.outb_mask == $past(wdata[9:0]))
      else $error("output mask not stored");
   a_pw_change_close: assert property (
      wr && addr == `RPE_A_PW_CHANGE && remote_open && wdata <= `RPE_MAX_PW |=>
         !remote_open && s.password == $past(wdata[9:0]))
      else $error("password change did not close");
   a_format_needs_open: assert property (
      format_start |-> $past(remote_open) && $past(wr) && $past(wdata) == `RPE_V_FORMAT)
      else $error("format without open access");
   a_station_range: assert property (
      s.station != 8'h00 && s.station != 8'hFF)
      else $error("station address out of range");
   a_evt_bound: assert property (
      s.count <= `RPE_EVT_DEPTH)
      else $error("event ring overfilled");
   a_evt_batch_drain: assert property (
      wr && addr == `RPE_A_EVT_CMD && wdata == `RPE_V_EVT_READ && !evt_valid &&
         s.count > 7'h05 |=> s.count == $past(s.count) - 7'h05 && s.buf_count == 3'h5)
      else $error("event batch not drained by five");
   a_state_clear: assert property (
      wr && addr == `RPE_A_MOD_STATE && wdata == `RPE_V_ZERO && !auto_reset_event &&
         !evt_valid |=> s.mod_state == 2'b00)
      else $error("module state not cleared");
   a_fault_alarm_pair: assert property (
      internal_fault_indicator == !alarm_relay_energized)
      else $error("indicator and alarm relay disagree");
   a_ctrl_fault_code: assert property (
      fault_flags[`RPE_F_CTRL] |=> s.fault_code == `RPE_C_CTRL && internal_fault_indicator)
      else $error("control circuit fault code wrong");
   a_time_bound: assert property (
      s.time_ms <= `RPE_MAX_TIME_MS)
      else $error("time beyond limit");
   // A mismatching password must leave remote setting closed.
   a_pw_open_reject: assert property (
      wr && addr == `RPE_A_PW_OPEN && wdata[9:0] != s.password && !remote_open |=>
         !remote_open)
      else $error("wrong password opened access");
   // Activation must light the indicator on the very next cycle.
   a_sup_lights_ind: assert property (
      wr && addr == `RPE_A_SUP_ACT && wdata == `RPE_V_ONE |=> internal_fault_indicator)
      else $error("supervision activation did not light indicator");
   // A re-read must neither move the ring nor disturb the kept batch.
   a_reread_keeps_batch: assert property (
      wr && addr == `RPE_A_EVT_CMD && wdata == `RPE_V_EVT_REREAD |=>
         $stable(s.rd_ptr) && $stable(s.buf_count))
      else $error("re-read changed the event ring");
   // The automatic-reset bit is set even when a clear arrives alongside.
   a_auto_reset_sets: assert property (
      auto_reset_event |=> s.mod_state[0])
      else $error("automatic reset not recorded");

   c_overflow: cover property (s.mod_state[1] && s.count == `RPE_EVT_DEPTH);
   c_batch_read: cover property (wr && addr == `RPE_A_EVT_CMD ##1 s.buf_count == 3'h5);
   c_pw_open: cover property ($rose(remote_open));
   c_format: cover property (format_start);
   c_time_wrap: cover property (s.time_ms == 16'h0000 && $past(s.time_ms) == `RPE_MAX_TIME_MS);
endmodule

// *** bench/rpe_comm.sv ***
// Bus master model of the control data communicator.
// Assumes the block answers a read in the cycle after the strobe, never stalling.
module rpe_comm (
   // Clock and answer.
   input wire logic clock,
   input wire logic [15:0] rdata,
   // Request lines.
   output logic [7:0] addr,
   output logic [15:0] wdata,
   output logic wr,
   output logic rd
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==================================================================
   // Idle bus from time zero.
   initial begin
      addr = 8'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
   end
   // One write cycle; stale data is inverted so it can never pass as fresh.
   task automatic put(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      wdata <= ~d;
   endtask
   // reads one register
   // One read cycle; the answer stands only in the following cycle.
   task automatic get(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      d = rdata;
   endtask
endmodule

// *** bench/relay_param_event_interface_tb.sv ***
// Self-checking bench of the relay parameter and event block.
// Assumes the bus master model drives the register port.
module relay_param_event_interface_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ==================================================================
   // Stimulus and observed signals.
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr, evt_channel, evt_code;
   logic [15:0] wdata, rdata, d;
   logic wr, rd, evt_valid, auto_reset_event;
   logic [10:0] fault_flags;
   logic [1:0] ref_gain;
   logic ind_clr, rel, rec_clr, bank, fmt, fault_ind, alarm, remote;
   logic [7:0] codes [7];
   int bad_count = 0;
   int checks = 0;
   int seed = 32'hb822;
   // Expected fault codes by flag; 7 and 8 depend on the gain.
   localparam logic [7:0] FC [11] = '{8'h04, 8'h1E, 8'h32, 8'h33, 8'h34, 8'h36,
      8'h38, 8'hC3, 8'hCB, 8'hFC, 8'hFD};
   localparam logic [15:0] MX [4] = '{16'h1000, 16'h1000, 16'h00FF, 16'h03FF};
   always #10 clock = ~clock;
   rpe_comm u_comm (.clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd));
   // Short millisecond so time logic moves within the run.
   rpe_top #(.CYC_PER_MS(4)) DUT (.clock(clock), .resetn(resetn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .evt_valid(evt_valid),
      .evt_channel(evt_channel), .evt_code(evt_code), .fault_flags(fault_flags),
      .ref_gain(ref_gain), .auto_reset_event(auto_reset_event),
      .indicators_clear(ind_clr), .latch_release(rel), .records_clear(rec_clr),
      .bank_select(bank), .format_start(fmt), .internal_fault_indicator(fault_ind),
      .alarm_relay_energized(alarm), .remote_open(remote));
   // ==================================================================
   // Expected fault code: gain 1 means x5, gain 2 means x25.
   function automatic logic [7:0] fcode(input int i, input logic [1:0] g);
      if (i == 7 || i == 8) begin
         return FC[i] - ((g == 2'h1) ? 8'h40 : (g == 2'h2) ? 8'h80 : 8'h00);
      end
      return FC[i];
   endfunction
   // Compare and count.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] v;
      u_comm.get(a, v);
      chk(what, exp, v);
   endtask
   // One event on the given channel; channel 5 is never masked.
   task automatic ev(input logic [7:0] ch, input logic [7:0] c);
      @(posedge clock);
      evt_valid <= 1'b1;
      evt_channel <= ch;
      evt_code <= c;
      @(posedge clock);
      evt_valid <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("Checks %0d errors %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected run length.
   initial begin
      #400_000;
      bad_count++;
      wrap_up();
   end
   // ==================================================================
   // Main sequence.
   initial begin
      {evt_valid, evt_channel, evt_code, auto_reset_event} = '0;
      fault_flags = 11'h000;
      ref_gain = 2'h0;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      rchk("station", 8'h0C, 16'h0001);
      chk("alarm", 16'h0001, {15'h0000, alarm});
      d = 16'({$random(seed)} % 254 + 1);
      u_comm.put(8'h0C, d);
      u_comm.put(8'h0C, 16'h00FF);
      u_comm.put(8'h0C, 16'h0000);
      rchk("station", 8'h0C, d);
      for (int i = 0; i < 4; i++) begin
         d = i[0] ? MX[i] : 16'({$random(seed)} % MX[i]);
         u_comm.put(8'h03 + 8'(i), d);
         u_comm.put(8'h03 + 8'(i), MX[i] + 16'h0001);
         rchk("mask", 8'h03 + 8'(i), d);
      end
      u_comm.put(8'h02, 16'h0001);
      u_comm.put(8'h02, 16'h0002);
      rchk("bank", 8'h02, 16'h0001);
      chk("bank_out", 16'h0001, {15'h0000, bank});
      u_comm.put(8'h0A, 16'h0002);
      @(negedge clock);
      chk("format", 16'h0000, {15'h0000, fmt});
      u_comm.put(8'h07, 16'h0001);
      rchk("remote", 8'h11, 16'h0001);
      u_comm.put(8'h0A, 16'h0002);
      @(negedge clock);
      chk("format", 16'h0001, {15'h0000, fmt});
      u_comm.put(8'h08, 16'h03E7);
      @(negedge clock);
      chk("remote", 16'h0000, {15'h0000, remote});
      u_comm.put(8'h08, 16'h0001);
      u_comm.put(8'h07, 16'h0001);
      rchk("remote", 8'h11, 16'h0000);
      u_comm.put(8'h07, 16'h03E7);
      rchk("remote", 8'h11, 16'h0001);
      u_comm.put(8'h09, 16'h0001);
      @(negedge clock);
      chk("fault_ind", 16'h0001, {15'h0000, fault_ind});
      // Indicator reset first, then full reset, which alone clears records.
      for (int i = 0; i < 2; i++) begin
         u_comm.put(8'(i), 16'h0001);
         @(negedge clock);
         chk("pulses", {13'h0000, 2'h3, i[0]}, {13'h0000, ind_clr, rel, rec_clr});
      end
      chk("fault_ind", 16'h0000, {15'h0000, fault_ind});
      // Each flag alone, then both memory blocks together.
      for (int i = 0; i < 12; i++) begin
         @(posedge clock);
         ref_gain <= 2'({$random(seed)} % 3);
         fault_flags <= (i == 11) ? 11'h018 : 11'h001 << i;
         repeat (2) @(posedge clock);
         d = (i == 11) ? 16'h0035 : {8'h00, fcode(i, ref_gain)};
         rchk("fault", 8'h0B, d);
         chk("ind_alarm", 16'h0002, {14'h0000, fault_ind, alarm});
      end
      @(posedge clock);
      fault_flags <= 11'h000;
      for (int i = 0; i < 7; i++) begin
         codes[i] = 8'($random(seed));
         ev(8'h05, codes[i]);
      end
      u_comm.put(8'h0D, 16'h0001);
      rchk("batch", 8'h0D, 16'h0005);
      rchk("left", 8'h0E, 16'h0002);
      for (int k = 0; k < 5; k++) begin
         rchk("evt", 8'h21 + 8'(2 * k), {8'h05, codes[k]});
      end
      u_comm.put(8'h0D, 16'h0002);
      u_comm.put(8'h0D, 16'h0002);
      rchk("evt", 8'h25, {8'h05, codes[2]});
      u_comm.put(8'h0D, 16'h0001);
      rchk("batch", 8'h0D, 16'h0002);
      rchk("evt", 8'h23, {8'h05, codes[6]});
      // Masked channels: only enabled code bits within the mask width are kept.
      u_comm.put(8'h06, 16'h0001);
      u_comm.put(8'h03, 16'h1000);
      ev(8'h03, 8'h00);
      ev(8'h03, 8'h01);
      ev(8'h03, 8'h0A);
      ev(8'h00, 8'h0C);
      ev(8'h00, 8'h0B);
      rchk("masked", 8'h0E, 16'h0002);
      u_comm.put(8'h0D, 16'h0001);
      rchk("evt_mask", 8'h21, 16'h0300);
      rchk("evt_mask", 8'h23, 16'h000C);
      repeat (66) ev(8'h05, 8'h11);
      rchk("count", 8'h0E, 16'h0041);
      rchk("state", 8'h0F, 16'h0002);
      @(posedge clock);
      auto_reset_event <= 1'b1;
      @(posedge clock);
      auto_reset_event <= 1'b0;
      rchk("state", 8'h0F, 16'h0003);
      u_comm.put(8'h0F, 16'h0000);
      rchk("state", 8'h0F, 16'h0000);
      u_comm.put(8'h10, 16'hEA5F);
      rchk("time", 8'h10, 16'hEA5F);
      repeat (2) @(posedge clock);
      rchk("time_wrap", 8'h10, 16'h0000);
      wrap_up();
   end
endmodule
